/* pkg/rafc_defines.svh */
// Register indices, field positions, reset values and counts of the bank.
`ifndef RAFC_DEFINES_SVH
`define RAFC_DEFINES_SVH

// Register indices; the byte address of each is four times its index.
`define RAFC_IDX_ED_LEVEL     8'h46
`define RAFC_IDX_DS_LIMIT     8'h48
`define RAFC_IDX_TONE_LIMIT   8'h4A
`define RAFC_IDX_SNR_FIRST    8'h4C
`define RAFC_IDX_SNR_SECOND   8'h4E
`define RAFC_IDX_DC_LIMIT     8'h50
`define RAFC_IDX_PRE_LEAD     8'h52
`define RAFC_IDX_PRE_LAG      8'h54
`define RAFC_IDX_PAY_LEAD     8'h56
`define RAFC_IDX_PAY_LAG      8'h58
`define RAFC_IDX_FA_TARGET    8'h5A
`define RAFC_IDX_TIMELINE     8'h5C
`define RAFC_IDX_ACQ_LIMITS   8'h5E
`define RAFC_IDX_LONG_SEED    8'h60
`define RAFC_IDX_SHORT_SEED   8'h62
`define RAFC_IDX_FIRST        `RAFC_IDX_ED_LEVEL
`define RAFC_IDX_LAST         `RAFC_IDX_SHORT_SEED
`define RAFC_SLOT(idx)        (((idx) - `RAFC_IDX_FIRST) >> 1)
`define RAFC_NUM_REGS         15

// Reset value of every stored register.
`define RAFC_RESET_VALUE      8'h00

// Field positions.
`define RAFC_BIT_ED_ABSOLUTE  7
`define RAFC_BIT_FORCE_DEF    6
`define RAFC_BIT_FORCE_CALC   5
`define RAFC_BIT_SHORT_ONLY   7
`define RAFC_BIT_DIV_STRENGTH 6
`define RAFC_BIT_FAR_DISABLE  7
`define RAFC_BIT_ED_QUALIFY   6
`define RAFC_BIT_VIEW_PRIMARY 7

// Bus answers.
`define RAFC_RESP_OKAY        2'b00
`define RAFC_RESP_SLVERR      2'b10

// False alarm control: target is N shifted by five per 2^16 trials.
`define RAFC_FAR_SHIFT        5
`define RAFC_FAR_WINDOW       16'hFFFF
`define RAFC_SQ_MAX           6'h3F

`endif

/* pkg/rafc_pkg.sv */
// Types shared by the acquisition configuration bank.
package rafc_pkg;
    `include "rafc_defines.svh"

    typedef logic [`RAFC_NUM_REGS-1:0][7:0] rafc_bank_type;

    typedef struct packed {
        logic [5:0] preLead;
        logic [5:0] preLag;
        logic [5:0] payLead;
        logic [5:0] payLag;
    } rafc_coef_type;

    typedef struct packed {
        logic        awReady;
        logic        wReady;
        logic        awGot;
        logic        wGot;
        logic [11:0] awAddr;
        logic [7:0]  wData;
        logic        wLow;
        logic        bValid;
        logic [1:0]  bResp;
        logic        arReady;
        logic        rValid;
        logic [1:0]  rResp;
        logic [7:0]  rData;
    } rafc_bus_type;

    typedef struct packed {
        rafc_bus_type  bus;
        rafc_bank_type regs;
        rafc_bank_type applied;
        logic [15:0]   farTrials;
        logic [16:0]   farAlarms;
        logic [5:0]    farThr;
        logic          edOut;
        logic          defOut;
        logic          dcOut;
        logic          acqOut;
        logic [5:0]    sq1Out;
        logic [6:0]    seedOut;
        rafc_coef_type coefOut;
    } rafc_state_type;
endpackage

/* verilog/rafc_config.sv */
// Acquisition and matched-filter configuration bank with AXI4-Lite access.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "rafc_defines.svh"

// How it works
// - Energy mode bit set: absolute level; clear: level above noise estimate.
// - Energy indication rises while strength exceeds the 7-bit level.
// - Default weights when tone present and strength below tone limit.
// - No tone: default weights below first SNR limit, or on low spread below the second limit.
// - Force-default bit always selects the default weights.
// - Tone strength limit is a 5-bit decibel field.
// - First SNR limit is the low 4-bit nibble.
// - Second SNR limit is a 5-bit decibel field.
// - DC offset work enabled when strength exceeds limit plus noise.
// - Four 6-bit loop coefficients for preamble and payload.
// - Rate logic adjusts first quality limit unless disabled.
// - First quality limit is 6 bits and seeds the adjustment.
// - Second quality limit is 6 bits for the verify cycle.
// - Qualifier bit adds energy indication to quality for detection.
// - Timeline disable bit treats every preamble as short.
// - Diversity metric uses channel factors, or strength when set.
// - Two 7-bit seeds; a configuration input picks one.
// - View bit selects primary read-only view when set.
// - Unused bits are stored and read back without effect.
// - Delay spread limit (low 5 bits) is compared with the delay spread input.
module rafc_config
    import rafc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        acqStart,
    input  wire logic [7:0]  receivedStrength,
    input  wire logic [7:0]  noiseLevelEstimate,
    input  wire logic        carrierToneDetected,
    input  wire logic [4:0]  delaySpread,
    input  wire logic [5:0]  signalQualityMeasure,
    input  wire logic        qualityTrial,
    input  wire logic        falseAlarm,
    input  wire logic        seedSelectConfig,
    output logic             energyOverLevel,
    output logic             useDefaultWeights,
    output logic             dcOffsetEnable,
    output logic             acqDetect,
    output logic [5:0]       signalQualityOneLimit,
    output logic [5:0]       signalQualityTwoLimit,
    output logic             shortPreambleOnly,
    output logic             diversityByStrength,
    output logic [6:0]       scramblerSeed,
    output logic             viewPrimary,
    output rafc_coef_type    loopCoef
);

    ////////////////////////////////////////////////////////////////////////
    localparam int SL_ED   = `RAFC_SLOT(`RAFC_IDX_ED_LEVEL);
    localparam int SL_DS   = `RAFC_SLOT(`RAFC_IDX_DS_LIMIT);
    localparam int SL_TONE = `RAFC_SLOT(`RAFC_IDX_TONE_LIMIT);
    localparam int SL_SNR1 = `RAFC_SLOT(`RAFC_IDX_SNR_FIRST);
    localparam int SL_SNR2 = `RAFC_SLOT(`RAFC_IDX_SNR_SECOND);
    localparam int SL_DC   = `RAFC_SLOT(`RAFC_IDX_DC_LIMIT);
    localparam int SL_PRLD = `RAFC_SLOT(`RAFC_IDX_PRE_LEAD);
    localparam int SL_PRLG = `RAFC_SLOT(`RAFC_IDX_PRE_LAG);
    localparam int SL_PYLD = `RAFC_SLOT(`RAFC_IDX_PAY_LEAD);
    localparam int SL_PYLG = `RAFC_SLOT(`RAFC_IDX_PAY_LAG);
    localparam int SL_FAR  = `RAFC_SLOT(`RAFC_IDX_FA_TARGET);
    localparam int SL_TL   = `RAFC_SLOT(`RAFC_IDX_TIMELINE);
    localparam int SL_AL   = `RAFC_SLOT(`RAFC_IDX_ACQ_LIMITS);
    localparam int SL_LSD  = `RAFC_SLOT(`RAFC_IDX_LONG_SEED);
    localparam int SL_SSD  = `RAFC_SLOT(`RAFC_IDX_SHORT_SEED);

    rafc_state_type state_reg;
    rafc_state_type state_next;

    ////////////////////////////////////////////////////////////////////////
    // Byte address to {hit, slot}; only aligned even indices are mapped.
    function automatic logic [4:0] rafc_decode(input logic [11:0] addr);
        logic [9:0] idx;
        logic [9:0] off;
        idx = addr[11:2];
        off = idx - 10'(`RAFC_IDX_FIRST);
        if (addr[1:0] == 2'b00 && !off[0]
                && idx >= 10'(`RAFC_IDX_FIRST)
                && idx <= 10'(`RAFC_IDX_LAST)) begin
            rafc_decode = {1'b1, off[4:1]};
        end else begin
            rafc_decode = 5'h00;
        end
    endfunction

    // Threshold plus noise estimate, one bit wider so it never wraps.
    function automatic logic [8:0] rafc_add(input logic [7:0] a,
                                            input logic [7:0] b);
        rafc_add = {1'b0, a} + {1'b0, b};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] edCfg;
    logic [7:0] dsCfg;
    logic [7:0] toneCfg;
    logic [7:0] snr1Cfg;
    logic [7:0] snr2Cfg;
    logic [7:0] dcCfg;
    logic [7:0] farCfg;
    logic [7:0] tlCfg;
    logic [7:0] alCfg;
    logic [7:0] seedCfg;
    logic [8:0] strength;
    logic [8:0] edLimit;
    logic       edHit;
    logic       toneLow;
    logic       snr1Low;
    logic       snr2Low;
    logic       spreadLow;
    logic       autoDefault;
    logic       wantDefault;
    logic       dcHit;
    logic [5:0] sq1Use;
    logic [5:0] sq1Prog;
    logic       acqHit;
    logic [16:0] farTarget;
    logic [5:0] farThr;

    assign edCfg    = state_reg.applied[SL_ED];
    assign dsCfg    = state_reg.applied[SL_DS];
    assign toneCfg  = state_reg.applied[SL_TONE];
    assign snr1Cfg  = state_reg.applied[SL_SNR1];
    assign snr2Cfg  = state_reg.applied[SL_SNR2];
    assign dcCfg    = state_reg.applied[SL_DC];
    assign farCfg   = state_reg.applied[SL_FAR];
    assign tlCfg    = state_reg.applied[SL_TL];
    assign alCfg    = state_reg.applied[SL_AL];
    assign strength = {1'b0, receivedStrength};
    assign sq1Prog  = alCfg[5:0];
    assign farThr   = state_reg.farThr;

    assign edLimit = edCfg[`RAFC_BIT_ED_ABSOLUTE]
                   ? {2'b00, edCfg[6:0]}
                   : rafc_add({1'b0, edCfg[6:0]}, noiseLevelEstimate);
    assign edHit = strength > edLimit;

    assign toneLow = strength
                   < rafc_add({3'b000, toneCfg[4:0]}, noiseLevelEstimate);
    assign snr1Low = strength
                   < rafc_add({4'h0, snr1Cfg[3:0]}, noiseLevelEstimate);
    assign snr2Low = strength
                   < rafc_add({3'b000, snr2Cfg[4:0]}, noiseLevelEstimate);
    assign spreadLow = delaySpread < dsCfg[4:0];

    assign autoDefault = carrierToneDetected
                       ? toneLow
                       : (snr1Low || (spreadLow && snr2Low));

    assign wantDefault = toneCfg[`RAFC_BIT_FORCE_DEF] ? 1'b1
                       : toneCfg[`RAFC_BIT_FORCE_CALC] ? 1'b0
                       : autoDefault;

    assign dcHit = strength
                 > rafc_add({2'b00, dcCfg[5:0]}, noiseLevelEstimate);

    // disabled rate logic keeps the programmed limit
    assign sq1Use = alCfg[`RAFC_BIT_FAR_DISABLE] ? sq1Prog : farThr;

    assign acqHit = (signalQualityMeasure >= sq1Use)
                 && (!alCfg[`RAFC_BIT_ED_QUALIFY] || edHit);

    // N times 32 alarms per window
    assign farTarget = 17'({farCfg, 5'b00000});

    assign seedCfg = seedSelectConfig ? state_reg.applied[SL_SSD]
                                      : state_reg.applied[SL_LSD];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [4:0] wDec;
        logic [4:0] rDec;
        wDec = rafc_decode(state_reg.bus.awAddr);
        rDec = rafc_decode(araddr);
        state_next = state_reg;

        if (awvalid && state_reg.bus.awReady) begin
            state_next.bus.awGot   = 1'b1;
            state_next.bus.awReady = 1'b0;
            state_next.bus.awAddr  = awaddr;
        end
        if (wvalid && state_reg.bus.wReady) begin
            state_next.bus.wGot   = 1'b1;
            state_next.bus.wReady = 1'b0;
            state_next.bus.wData  = wdata[7:0];
            state_next.bus.wLow   = wstrb[0];
        end
        if (state_reg.bus.awGot && state_reg.bus.wGot
                && !state_reg.bus.bValid) begin
            state_next.bus.awGot  = 1'b0;
            state_next.bus.wGot   = 1'b0;
            state_next.bus.bValid = 1'b1;
            if (wDec[4]) begin
                state_next.bus.bResp = `RAFC_RESP_OKAY;
                // all eight bits stored as written
                // spread count kept with its field
                if (state_reg.bus.wLow) begin
                    state_next.regs[wDec[3:0]] = state_reg.bus.wData;
                end
            end else begin
                state_next.bus.bResp = `RAFC_RESP_SLVERR;
            end
        end
        if (state_reg.bus.bValid && bready) begin
            state_next.bus.bValid  = 1'b0;
            state_next.bus.awReady = 1'b1;
            state_next.bus.wReady  = 1'b1;
        end

        if (arvalid && state_reg.bus.arReady) begin
            state_next.bus.arReady = 1'b0;
            state_next.bus.rValid  = 1'b1;
            if (rDec[4]) begin
                state_next.bus.rResp = `RAFC_RESP_OKAY;
                state_next.bus.rData = state_reg.regs[rDec[3:0]];
            end else begin
                state_next.bus.rResp = `RAFC_RESP_SLVERR;
                state_next.bus.rData = 8'h00;
            end
        end
        if (state_reg.bus.rValid && rready) begin
            state_next.bus.rValid  = 1'b0;
            state_next.bus.arReady = 1'b1;
        end

        if (acqStart) begin
            state_next.applied = state_reg.regs;
        end

        if (alCfg[`RAFC_BIT_FAR_DISABLE]) begin
            state_next.farThr    = sq1Prog;
            state_next.farTrials = 16'h0000;
            state_next.farAlarms = 17'h0_0000;
        end else if (qualityTrial) begin
            state_next.farTrials = state_reg.farTrials + 16'h0001;
            if (falseAlarm) begin
                state_next.farAlarms = state_reg.farAlarms + 17'h0_0001;
            end
            if (state_reg.farTrials == `RAFC_FAR_WINDOW) begin
                state_next.farAlarms = 17'h0_0000;
                if (state_reg.farAlarms > farTarget
                        && farThr != `RAFC_SQ_MAX) begin
                    state_next.farThr = farThr + 6'h01;
                end else if (state_reg.farAlarms < farTarget
                        && farThr != 6'h00) begin
                    state_next.farThr = farThr - 6'h01;
                end
            end
        end

        state_next.edOut   = edHit;
        state_next.defOut  = wantDefault;
        state_next.dcOut   = dcHit;
        state_next.acqOut  = acqHit;
        state_next.sq1Out  = sq1Use;
        state_next.seedOut = seedCfg[6:0];
        state_next.coefOut.preLead = state_reg.applied[SL_PRLD][5:0];
        state_next.coefOut.preLag  = state_reg.applied[SL_PRLG][5:0];
        state_next.coefOut.payLead = state_reg.applied[SL_PYLD][5:0];
        state_next.coefOut.payLag  = state_reg.applied[SL_PYLG][5:0];
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg             <= '0;
            state_reg.regs        <= {`RAFC_NUM_REGS{`RAFC_RESET_VALUE}};
            state_reg.applied     <= {`RAFC_NUM_REGS{`RAFC_RESET_VALUE}};
            state_reg.bus.awReady <= 1'b1;
            state_reg.bus.wReady  <= 1'b1;
            state_reg.bus.arReady <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign awready               = state_reg.bus.awReady;
    assign wready                = state_reg.bus.wReady;
    assign bvalid                = state_reg.bus.bValid;
    assign bresp                 = state_reg.bus.bResp;
    assign arready               = state_reg.bus.arReady;
    assign rvalid                = state_reg.bus.rValid;
    assign rresp                 = state_reg.bus.rResp;
    assign rdata                 = {24'h00_0000, state_reg.bus.rData};
    assign energyOverLevel       = state_reg.edOut;
    assign useDefaultWeights     = state_reg.defOut;
    assign dcOffsetEnable        = state_reg.dcOut;
    assign acqDetect             = state_reg.acqOut;
    assign signalQualityOneLimit = state_reg.sq1Out;
    assign signalQualityTwoLimit = tlCfg[5:0];
    assign shortPreambleOnly     = tlCfg[`RAFC_BIT_SHORT_ONLY];
    assign diversityByStrength   = tlCfg[`RAFC_BIT_DIV_STRENGTH];
    assign scramblerSeed         = state_reg.seedOut;
    assign viewPrimary = state_reg.applied[SL_SSD][`RAFC_BIT_VIEW_PRIMARY];
    assign loopCoef              = state_reg.coefOut;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_ed_absolute: assert property (
        edCfg[7] && strength > {2'b00, edCfg[6:0]} |=> energyOverLevel)
        else $error("absolute energy level not flagged");

    a_ed_relative: assert property (
        !edCfg[7] && strength <= rafc_add({1'b0, edCfg[6:0]},
                                          noiseLevelEstimate)
        |=> !energyOverLevel)
        else $error("energy flag without exceeding level");

    a_tone_default: assert property (
        toneCfg[6:5] == 2'b00 && carrierToneDetected && toneLow
        |=> useDefaultWeights)
        else $error("tone case did not pick default weights");

    a_snr_default: assert property (
        toneCfg[6:5] == 2'b00 && !carrierToneDetected
        && !snr1Low && !(spreadLow && snr2Low) |=> !useDefaultWeights)
        else $error("no-tone case picked default weights");

    a_force_default: assert property (
        toneCfg[6] |=> useDefaultWeights)
        else $error("forced default ignored");

    a_force_calc: assert property (
        toneCfg[6:5] == 2'b01 |=> !useDefaultWeights)
        else $error("forced calculated ignored");

    a_dc_enable: assert property (
        dcOffsetEnable == $past(dcHit))
        else $error("DC enable does not follow strength");

    a_far_hold: assert property (
        alCfg[7] [*2] |-> signalQualityOneLimit == $past(sq1Prog))
        else $error("disabled rate logic moved the limit");

    a_far_raise: assert property (
        !alCfg[7] && qualityTrial && state_reg.farTrials == 16'hFFFF
        && state_reg.farAlarms > farTarget && farThr != 6'h3F
        |=> farThr == $past(farThr) + 6'h01)
        else $error("limit not raised after too many alarms");

    a_acq_qualify: assert property (
        alCfg[6] && !edHit |=> !acqDetect)
        else $error("detection without energy qualifier");

    a_apply_next: assert property (
        !acqStart |=> $stable(state_reg.applied))
        else $error("configuration applied outside acquisition start");

    a_write_answer: assert property (
        state_reg.bus.awGot && state_reg.bus.wGot && !bvalid
        |=> bvalid ##0 !awready ##0 !wready)
        else $error("write response missing");

    c_write_done: cover property (bvalid && bready);
    c_read_done: cover property (rvalid && rready);
    c_default_pick: cover property (!useDefaultWeights ##1 useDefaultWeights);
    c_far_adjust: cover property (farThr != $past(farThr) && !alCfg[7]);

endmodule

/* testbench/tb.sv */
// Self-checking bench for the acquisition configuration bank.
`timescale 1ns/1ps
`include "rafc_defines.svh"
module tb
    import rafc_pkg::*;
;
    logic          ref_clk, rst_n, awvalid, awready, wvalid, wready, bvalid;
    logic          bready, arvalid, arready, rvalid, rready, acqStart, tone;
    logic          trial, alarm, seedSel, eol, useDef, dcEn, acqDet;
    logic          shortOnly, divStr, viewPri;
    logic [11:0]   awaddr, araddr;
    logic [31:0]   wdata, rdata;
    logic [3:0]    wstrb, strb;
    logic [1:0]    bresp, rresp;
    logic [7:0]    strength, noise;
    logic [4:0]    spread;
    logic [5:0]    sqMeas, sq1, sq2;
    logic [6:0]    scrSeed;
    rafc_coef_type loopCoef;
    logic [1:0]    bq[$];
    logic [33:0]   rq[$];
    integer        seed;
    int            failures, n_compared;

    rafc_config uut (.ref_clk(ref_clk), .rst_n(rst_n), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .acqStart(acqStart), .receivedStrength(strength),
        .noiseLevelEstimate(noise), .carrierToneDetected(tone),
        .delaySpread(spread), .signalQualityMeasure(sqMeas),
        .qualityTrial(trial), .falseAlarm(alarm),
        .seedSelectConfig(seedSel), .energyOverLevel(eol),
        .useDefaultWeights(useDef), .dcOffsetEnable(dcEn),
        .acqDetect(acqDet), .signalQualityOneLimit(sq1),
        .signalQualityTwoLimit(sq2), .shortPreambleOnly(shortOnly),
        .diversityByStrength(divStr), .scramblerSeed(scrSeed),
        .viewPrimary(viewPri), .loopCoef(loopCoef));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task stop_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk(string what, logic [33:0] exp, logic [33:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task cmp(string what, logic [23:0] exp, logic [23:0] got);
        chk(what, {10'h000, exp}, {10'h000, got});
    endtask

    function automatic logic [11:0] ba(logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus answers are compared against the oldest note as they appear.
    always @(posedge ref_clk) begin
        if (bvalid === 1'b1 && bready === 1'b1)
            chk("bresp", 34'(bq.pop_front()), 34'(bresp));
        if (rvalid === 1'b1 && rready === 1'b1)
            chk("read", rq.pop_front(), {rresp, rdata});
    end

    task wr(logic [7:0] idx, logic [31:0] d, logic [1:0] r);
        bq.push_back(r);
        awaddr <= ba(idx);
        wdata <= d;
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task rd(logic [7:0] idx, logic [33:0] e);
        rq.push_back(e);
        araddr <= ba(idx);
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Applies the stored set and presents one set of receive conditions.
    task go(logic [7:0] s, logic t);
        @(posedge ref_clk);
        acqStart <= 1'b1;
        strength <= s;
        tone <= t;
        spread <= 5'($random(seed));
        sqMeas <= 6'($random(seed));
        @(posedge ref_clk);
        acqStart <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(40 * 80000);
        failures++;
        stop_test;
    end

    initial begin
        logic [31:0] d;
        logic [7:0]  idx;
        seed = 32'h77ef;
        strb = 4'h1;
        failures = 0;
        n_compared = 0;
        {rst_n, awvalid, wvalid, bready, arvalid, rready} <= 6'h00;
        {acqStart, tone, trial, alarm, seedSel} <= 5'h00;
        {awaddr, araddr, wdata, wstrb} <= 60'h0;
        {strength, spread, sqMeas} <= 19'h0;
        noise <= 8'd20;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        for (int i = 0; i < `RAFC_NUM_REGS; i++)
            rd(`RAFC_IDX_FIRST + 8'(2 * i), 34'h0);
        rd(8'h47, {`RAFC_RESP_SLVERR, 32'h0000_0000});
        wr(8'h64, 32'h0000_00FF, `RAFC_RESP_SLVERR);
        for (int i = 0; i < `RAFC_NUM_REGS; i++) begin
            idx = `RAFC_IDX_FIRST + 8'(2 * i);
            d = $random(seed);
            wr(idx, d, `RAFC_RESP_OKAY);
            rd(idx, {2'b00, 24'h00_0000, d[7:0]});
        end
        // Energy detect, absolute then relative to the noise estimate.
        wr(`RAFC_IDX_ED_LEVEL, 32'h0000_008A, `RAFC_RESP_OKAY);
        go(8'd25, 1'b0);
        cmp("eol", 1'b1, eol);
        go(8'd10, 1'b0);
        cmp("eol", 1'b0, eol);
        wr(`RAFC_IDX_ED_LEVEL, 32'h0000_000A, `RAFC_RESP_OKAY);
        go(8'd25, 1'b0);
        cmp("eol", 1'b0, eol);
        go(8'd31, 1'b0);
        cmp("eol", 1'b1, eol);
        // Matched-filter weight selection with its boundaries.
        wr(`RAFC_IDX_DS_LIMIT, 32'h0000_00E0, `RAFC_RESP_OKAY);
        wr(`RAFC_IDX_SNR_FIRST, 32'h0000_0004, `RAFC_RESP_OKAY);
        wr(`RAFC_IDX_SNR_SECOND, 32'h0000_0000, `RAFC_RESP_OKAY);
        wr(`RAFC_IDX_TONE_LIMIT, 32'h0000_0005, `RAFC_RESP_OKAY);
        go(8'd24, 1'b1);
        cmp("default", 1'b1, useDef);
        go(8'd25, 1'b1);
        cmp("default", 1'b0, useDef);
        go(8'd23, 1'b0);
        cmp("default", 1'b1, useDef);
        go(8'd24, 1'b0);
        cmp("default", 1'b0, useDef);
        wr(`RAFC_IDX_TONE_LIMIT, 32'h0000_0045, `RAFC_RESP_OKAY);
        go(8'd25, 1'b1);
        cmp("default", 1'b1, useDef);
        wr(`RAFC_IDX_TONE_LIMIT, 32'h0000_0025, `RAFC_RESP_OKAY);
        go(8'd24, 1'b1);
        cmp("default", 1'b0, useDef);
        // DC offset enable around its limit, unused bits set.
        wr(`RAFC_IDX_DC_LIMIT, 32'h0000_00C6, `RAFC_RESP_OKAY);
        go(8'd27, 1'b0);
        cmp("dc", 1'b1, dcEn);
        go(8'd26, 1'b0);
        cmp("dc", 1'b0, dcEn);
        // Static settings carried to the receive side.
        wr(`RAFC_IDX_TIMELINE, 32'h0000_00C5, `RAFC_RESP_OKAY);
        wr(`RAFC_IDX_ACQ_LIMITS, 32'h0000_00AA, `RAFC_RESP_OKAY);
        wr(`RAFC_IDX_LONG_SEED, 32'h0000_0011, `RAFC_RESP_OKAY);
        wr(`RAFC_IDX_SHORT_SEED, 32'h0000_00B3, `RAFC_RESP_OKAY);
        wr(`RAFC_IDX_PRE_LEAD, 32'h0000_0020, `RAFC_RESP_OKAY);
        wr(`RAFC_IDX_PRE_LAG, 32'h0000_0001, `RAFC_RESP_OKAY);
        wr(`RAFC_IDX_PAY_LEAD, 32'h0000_001F, `RAFC_RESP_OKAY);
        wr(`RAFC_IDX_PAY_LAG, 32'h0000_0010, `RAFC_RESP_OKAY);
        go(8'd0, 1'b0);
        cmp("short", 1'b1, shortOnly);
        cmp("diversity", 1'b1, divStr);
        cmp("sq2", 6'h05, sq2);
        cmp("sq1", 6'h2A, sq1);
        cmp("view", 1'b1, viewPri);
        cmp("seed", 7'h11, scrSeed);
        cmp("coef", {6'h20, 6'h01, 6'h1F, 6'h10}, loopCoef);
        seedSel <= 1'b1;
        repeat (3) @(posedge ref_clk);
        cmp("seed", 7'h33, scrSeed);
        // Lane zero strobe low answers but leaves the register untouched.
        strb = 4'h0;
        wr(`RAFC_IDX_LONG_SEED, 32'h0000_0055, `RAFC_RESP_OKAY);
        strb = 4'h1;
        rd(`RAFC_IDX_LONG_SEED, 34'h0_0000_0011);
        // Detection against the quality limit, alone and with energy.
        sqMeas <= 6'h2A;
        repeat (2) @(posedge ref_clk);
        cmp("acq", 1'b1, acqDet);
        sqMeas <= 6'h29;
        repeat (2) @(posedge ref_clk);
        cmp("acq", 1'b0, acqDet);
        wr(`RAFC_IDX_ACQ_LIMITS, 32'h0000_006A, `RAFC_RESP_OKAY);
        go(8'h1F, 1'b0);
        sqMeas <= 6'h3F;
        repeat (2) @(posedge ref_clk);
        cmp("acq", 1'b1, acqDet);
        strength <= 8'h1E;
        repeat (2) @(posedge ref_clk);
        cmp("acq", 1'b0, acqDet);
        // One full window of trials, all false alarms, raises the limit.
        trial <= 1'b1;
        alarm <= 1'b1;
        repeat (32'(`RAFC_FAR_WINDOW) + 1) @(posedge ref_clk);
        trial <= 1'b0;
        alarm <= 1'b0;
        repeat (2) @(posedge ref_clk);
        cmp("sq1", 6'h2B, sq1);
        stop_test;
    end
endmodule
